// ===== design/tmt_pkg.sv
// Constants and carrier types shared by the three-mode interval timer.
package tmt_pkg;

  localparam int TMT_CNT_W = 16;

  // Register byte offsets on the bus.
  localparam logic [7:0] TMT_ADR_MODE = 8'h00;
  localparam logic [7:0] TMT_ADR_START = 8'h04;
  localparam logic [7:0] TMT_ADR_DATA = 8'h08;
  localparam logic [7:0] TMT_ADR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] TMT_ADR_IRQ_MASK = 8'h10;

  // Mode register field positions, then the start and interrupt bit positions.
  localparam int TMT_MODE_LSB = 0;
  localparam int TMT_EDGE_LSB = 2;
  localparam int TMT_WIDTH_BIT = 3;
  localparam int TMT_RISE_BIT = 2;
  localparam int TMT_OVF_BIT = 5;
  localparam int TMT_CS_LSB = 6;
  localparam int TMT_START_BIT = 0;
  localparam int TMT_IRQ_BIT = 0;

  // Writable bits of the mode register; the overflow flag and bit 4 are not.
  localparam logic [7:0] TMT_MODE_WMASK = 8'hCF;

  // Reset values and counter constants.
  localparam logic [7:0] TMT_MODE_RST = 8'h20;
  localparam logic [15:0] TMT_CNT_RST = 16'h0000;
  localparam logic [15:0] TMT_CNT_ALL1 = 16'hFFFF;
  localparam logic [15:0] TMT_CNT_ONE = 16'h0001;
  localparam logic TMT_START_RST = 1'b0;
  localparam logic TMT_MASK_RST = 1'b0;

  // Prescaler: the count sources divide the system clock by 2**shift.
  localparam int TMT_PS_W = 9;
  localparam int TMT_PS_SHIFT [4] = '{0, 3, 5, 9};
  localparam logic [8:0] TMT_PS_RST = 9'h000;
  localparam logic [8:0] TMT_PS_ONE = 9'h001;

  typedef enum logic [1:0] {
    TMT_MD_TIMER = 2'h0,
    TMT_MD_EVENT = 2'h1,
    TMT_MD_MEASURE = 2'h2,
    TMT_MD_RSVD = 2'h3
  } tmt_mode_t;

  typedef enum logic [1:0] {
    TMT_EDGE_FALL = 2'h0,
    TMT_EDGE_RISE = 2'h1,
    TMT_EDGE_BOTH = 2'h2,
    TMT_EDGE_NONE = 2'h3
  } tmt_edge_t;

  // Count-source strobes and input edges, one cycle each.
  typedef struct packed {
    logic [3:0] tick;
    logic rise;
    logic fall;
  } tmt_strobe_t;

  // One Wishbone request as seen by the slave.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } tmt_wb_req_t;

  typedef struct packed {
    logic [TMT_PS_W-1:0] ps_cnt;
    logic sync1;
    logic sync2;
    logic last;
  } tmt_gen_state_t;

  typedef struct packed {
    logic [7:0] mode_reg;
    logic run;
    logic first_cap;
    logic [15:0] reload;
    logic [15:0] count;
    logic irq_stat;
    logic irq_mask;
    logic ack;
    logic [31:0] rdata;
  } tmt_state_t;

endpackage

// ===== design/tmt_strobe_gen.sv
// Prescaler strobes and synchronised edge detection for the interval timer.
`timescale 1ns/100ps
`default_nettype none
module tmt_strobe_gen
  import tmt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // External pin
  input wire logic event_measure_input,
  // Strobes to the timer core
  output tmt_strobe_t strobe
);

  tmt_gen_state_t st_ff;
  tmt_gen_state_t nxt_st;
  logic [3:0] tick_w;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tick
      if (TMT_PS_SHIFT[g] == 0) begin : g_full
        assign tick_w[g] = 1'b1;
      end else begin : g_div
        assign tick_w[g] = &st_ff.ps_cnt[TMT_PS_SHIFT[g]-1:0];
      end
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ps_cnt = st_ff.ps_cnt + TMT_PS_ONE;
    nxt_st.sync1 = event_measure_input;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.last = st_ff.sync2;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Edges come from the second and third stages only.
  assign strobe.tick = tick_w;
  assign strobe.rise = st_ff.sync2 & ~st_ff.last;
  assign strobe.fall = ~st_ff.sync2 & st_ff.last;

endmodule
`default_nettype wire

// ===== design/tmt_interval_timer.sv
// Three-mode 16-bit interval timer with a Wishbone register slave.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tmt_interval_timer
  import tmt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External event or measurement pin
  input wire logic event_measure_input,
  // Interrupt
  output logic irq
);

  tmt_state_t st_ff;
  tmt_state_t nxt_st;
  tmt_strobe_t strb;
  tmt_wb_req_t bus;
  tmt_mode_t mode;
  tmt_edge_t edge_sel;
  logic bus_req;
  logic bus_wr;
  logic wr_data;
  logic tick;
  logic ev_edge;
  logic meas_edge;
  logic reach0;
  logic cap;
  logic [15:0] wdata;
  logic [31:0] rd_mux;

  tmt_strobe_gen u_strobe (
    .clk_sys(clk_sys),
    .rst(rst),
    .event_measure_input(event_measure_input),
    .strobe(strb)
  );

  assign bus.cyc = wb_cyc_i;
  assign bus.stb = wb_stb_i;
  assign bus.we = wb_we_i;
  assign bus.sel = wb_sel_i;
  assign bus.adr = wb_adr_i;
  assign bus.dat = wb_dat_i;

  // A write lands on the edge where the master samples ack high.
  assign bus_req = bus.cyc & bus.stb;
  assign bus_wr = bus_req & bus.we & st_ff.ack;
  assign wr_data = bus_wr && (bus.adr == TMT_ADR_DATA) && (bus.sel[1:0] != 2'h0);

  assign mode = tmt_mode_t'(st_ff.mode_reg[TMT_MODE_LSB +: 2]);
  assign edge_sel = tmt_edge_t'(st_ff.mode_reg[TMT_EDGE_LSB +: 2]);

  assign tick = strb.tick[st_ff.mode_reg[TMT_CS_LSB +: 2]];

  always_comb begin
    case (edge_sel)
      TMT_EDGE_FALL: ev_edge = strb.fall;
      TMT_EDGE_RISE: ev_edge = strb.rise;
      TMT_EDGE_BOTH: ev_edge = strb.rise | strb.fall;
      default: ev_edge = 1'b0;
    endcase
  end

  // period edge, width uses both edges
  always_comb begin
    if (st_ff.mode_reg[TMT_WIDTH_BIT]) begin
      meas_edge = strb.rise | strb.fall;
    end else if (st_ff.mode_reg[TMT_RISE_BIT]) begin
      meas_edge = strb.rise;
    end else begin
      meas_edge = strb.fall;
    end
  end

  // Byte lanes of the data register.
  assign wdata[7:0] = bus.sel[0] ? bus.dat[7:0] : st_ff.reload[7:0];
  assign wdata[15:8] = bus.sel[1] ? bus.dat[15:8] : st_ff.reload[15:8];

  // captured value read in measure mode
  always_comb begin
    if (bus.adr == TMT_ADR_MODE) begin
      rd_mux = {24'h000000, st_ff.mode_reg};
    end else if (bus.adr == TMT_ADR_START) begin
      rd_mux = {31'h00000000, st_ff.run};
    end else if (bus.adr == TMT_ADR_DATA) begin
      rd_mux = {16'h0000, (mode == TMT_MD_MEASURE) ? st_ff.reload : st_ff.count};
    end else if (bus.adr == TMT_ADR_IRQ_STAT) begin
      rd_mux = {31'h00000000, st_ff.irq_stat};
    end else if (bus.adr == TMT_ADR_IRQ_MASK) begin
      rd_mux = {31'h00000000, st_ff.irq_mask};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    reach0 = 1'b0;
    cap = 1'b0;
    nxt_st.ack = bus_req & ~st_ff.ack;
    if (bus_req && !st_ff.ack && !bus.we) begin
      nxt_st.rdata = rd_mux;
    end
    // Software side first, so that hardware events below win.
    if (bus_wr) begin
      if (bus.adr == TMT_ADR_MODE) begin
        if (bus.sel[0]) begin
          nxt_st.mode_reg = bus.dat[7:0] & TMT_MODE_WMASK;
        end
      end else if (bus.adr == TMT_ADR_START) begin
        if (bus.sel[0]) begin
          nxt_st.run = bus.dat[TMT_START_BIT];
          if (bus.dat[TMT_START_BIT] && !st_ff.run) begin
            nxt_st.first_cap = 1'b1;
          end
        end
      end else if (bus.adr == TMT_ADR_DATA) begin
        if (bus.sel[1:0] != 2'h0) begin
          nxt_st.reload = wdata;
          if (!st_ff.run) begin
            nxt_st.count = wdata;
          end
        end
      end else if (bus.adr == TMT_ADR_IRQ_STAT) begin
        if (bus.sel[0] && bus.dat[TMT_IRQ_BIT]) begin
          nxt_st.irq_stat = 1'b0;
        end
      end else if (bus.adr == TMT_ADR_IRQ_MASK) begin
        if (bus.sel[0]) begin
          nxt_st.irq_mask = bus.dat[TMT_IRQ_BIT];
        end
      end
    end
    if (st_ff.run) begin
      case (mode)
        TMT_MD_TIMER, TMT_MD_EVENT: begin
          if ((mode == TMT_MD_TIMER) ? tick : ev_edge) begin
            if (st_ff.count == TMT_CNT_RST) begin
              nxt_st.count = st_ff.reload;
              reach0 = 1'b1;
            end else begin
              nxt_st.count = st_ff.count - TMT_CNT_ONE;
            end
          end
        end
        TMT_MD_MEASURE: begin
          // capture then clear, restart next tick
          if (meas_edge) begin
            nxt_st.reload = st_ff.count;
            nxt_st.count = TMT_CNT_RST;
            nxt_st.first_cap = 1'b0;
            cap = 1'b1;
          end else if (tick) begin
            nxt_st.count = st_ff.count + TMT_CNT_ONE;
            reach0 = (st_ff.count == TMT_CNT_ALL1);
          end
        end
        default: begin
          nxt_st.count = st_ff.count;
        end
      endcase
    end
    if (reach0) begin
      nxt_st.mode_reg[TMT_OVF_BIT] = 1'b1;
    end
    // capture interrupt skips the first one
    if ((reach0 && mode != TMT_MD_MEASURE) || (cap && !st_ff.first_cap)) begin
      nxt_st.irq_stat = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff.mode_reg <= TMT_MODE_RST;
      st_ff.run <= TMT_START_RST;
      st_ff.first_cap <= 1'b0;
      st_ff.reload <= TMT_CNT_RST;
      st_ff.count <= TMT_CNT_RST;
      st_ff.irq_stat <= 1'b0;
      st_ff.irq_mask <= TMT_MASK_RST;
      st_ff.ack <= 1'b0;
      st_ff.rdata <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;

  // interrupt is the only output besides the bus, no pulse pin
  assign irq = st_ff.irq_stat & st_ff.irq_mask;

  // Assertions. Measurement intervals shorter than two count-source cycles are
  // the pin source's fault; the checks below do not depend on them.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_mode_rsvd_hold: assert property (
    (st_ff.run && mode == TMT_MD_RSVD && !wr_data) |=> $stable(st_ff.count))
    else $error("reserved mode changed the counter");

  a_timer_halt_hold: assert property (
    (!st_ff.run && mode == TMT_MD_TIMER && !wr_data) |=> $stable(st_ff.count))
    else $error("halted timer changed its counter");

  a_timer_decrement: assert property (
    (st_ff.run && mode == TMT_MD_TIMER && tick && st_ff.count != TMT_CNT_RST)
    |=> st_ff.count == $past(st_ff.count) - TMT_CNT_ONE)
    else $error("timer did not decrement by one");

  a_timer_reload_irq: assert property (
    (st_ff.run && mode == TMT_MD_TIMER && tick && st_ff.count == TMT_CNT_RST)
    |=> (st_ff.count == $past(st_ff.reload)) && st_ff.irq_stat)
    else $error("timer zero did not reload and request");

  a_write_halted: assert property (
    (wr_data && !st_ff.run && bus.sel[1:0] == 2'h3)
    |=> (st_ff.count == $past(bus.dat[15:0])) && (st_ff.reload == $past(bus.dat[15:0])))
    else $error("halted write did not load counter and reload");

  a_write_running: assert property (
    (wr_data && st_ff.run && mode == TMT_MD_TIMER && !tick && bus.sel[1:0] == 2'h3)
    |=> $stable(st_ff.count) && (st_ff.reload == $past(bus.dat[15:0])))
    else $error("running write touched the counter");

  a_event_count: assert property (
    (st_ff.run && mode == TMT_MD_EVENT && ev_edge && st_ff.count != TMT_CNT_RST)
    |=> st_ff.count == $past(st_ff.count) - TMT_CNT_ONE)
    else $error("event edge not counted");

  a_event_ignores_tick: assert property (
    (st_ff.run && mode == TMT_MD_EVENT && !ev_edge && !wr_data) |=> $stable(st_ff.count))
    else $error("event mode counted without an edge");

  a_event_reload: assert property (
    (st_ff.run && mode == TMT_MD_EVENT && ev_edge && st_ff.count == TMT_CNT_RST)
    |=> (st_ff.count == $past(st_ff.reload)) && st_ff.irq_stat)
    else $error("event mode zero did not reload and request");

  a_period_rise_only: assert property (
    (st_ff.run && mode == TMT_MD_MEASURE && !st_ff.mode_reg[TMT_WIDTH_BIT]
     && st_ff.mode_reg[TMT_RISE_BIT] && strb.fall && !wr_data)
    |=> $stable(st_ff.reload))
    else $error("rising period mode reacted to a falling edge");

  a_capture_clear: assert property (
    (st_ff.run && mode == TMT_MD_MEASURE && meas_edge)
    |=> (st_ff.reload == $past(st_ff.count)) && (st_ff.count == TMT_CNT_RST))
    else $error("measuring edge did not capture and clear");

  a_first_cap_quiet: assert property (
    (st_ff.run && mode == TMT_MD_MEASURE && meas_edge && st_ff.first_cap
     && !st_ff.irq_stat && !bus_wr)
    |=> !st_ff.irq_stat)
    else $error("first capture after start raised a request");

  a_later_cap_irq: assert property (
    (st_ff.run && mode == TMT_MD_MEASURE && meas_edge && !st_ff.first_cap) |=> st_ff.irq_stat)
    else $error("capture did not raise a request");

  a_width_both_edges: assert property (
    (st_ff.run && mode == TMT_MD_MEASURE && st_ff.mode_reg[TMT_WIDTH_BIT]
     && (strb.rise || strb.fall))
    |=> st_ff.count == TMT_CNT_RST)
    else $error("width mode missed an edge");

  a_measure_read: assert property (
    (bus_req && !st_ff.ack && !bus.we && bus.adr == TMT_ADR_DATA && mode == TMT_MD_MEASURE)
    |=> wb_ack_o && (wb_dat_o[15:0] == $past(st_ff.reload)))
    else $error("measure read did not return the captured value");

  a_ovf_set: assert property (
    (st_ff.run && mode == TMT_MD_TIMER && tick && st_ff.count == TMT_CNT_RST)
    |=> st_ff.mode_reg[TMT_OVF_BIT])
    else $error("overflow flag not set at zero");

  a_measure_halt: assert property (
    (!st_ff.run && mode == TMT_MD_MEASURE && !bus_wr)
    |=> $stable(st_ff.count) && $stable(st_ff.reload))
    else $error("halted measurement moved");

  a_edge_none_hold: assert property (
    (st_ff.run && mode == TMT_MD_EVENT && edge_sel == TMT_EDGE_NONE && !wr_data)
    |=> $stable(st_ff.count))
    else $error("event mode with no edge selected moved the counter");

  a_event_ovf_set: assert property (
    (st_ff.run && mode == TMT_MD_EVENT && ev_edge && st_ff.count == TMT_CNT_RST)
    |=> st_ff.mode_reg[TMT_OVF_BIT])
    else $error("event mode zero did not set the overflow flag");

  a_ovf_write_clear: assert property (
    (bus_wr && bus.adr == TMT_ADR_MODE && bus.sel[0] && !reach0)
    |=> !st_ff.mode_reg[TMT_OVF_BIT])
    else $error("mode write did not clear the overflow flag");

  a_stat_sticky: assert property (
    (st_ff.irq_stat && !(bus_wr && bus.adr == TMT_ADR_IRQ_STAT && bus.sel[0]
     && bus.dat[TMT_IRQ_BIT]))
    |=> st_ff.irq_stat)
    else $error("request bit dropped without a clear");

  a_ack_latency: assert property (
    (bus_req && !wb_ack_o) |=> wb_ack_o)
    else $error("ack did not follow the request by one cycle");

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

endmodule
`default_nettype wire

// ===== verification/tmt_pulse_src.sv
// Behavioural external pulse source that drives the event and measurement pin.
`timescale 1ns/100ps
`default_nettype none
module tmt_pulse_src (
  // Clock
  input wire logic clk_sys,
  // Burst control
  input wire logic go,
  input wire logic [7:0] half,
  input wire logic [7:0] n_tog,
  // Pin and status
  output logic pin,
  output logic busy
);
  int left = 0;
  int cnt = 0;
  logic pin_q = 1'b0;
  logic busy_q = 1'b0;
  assign pin = pin_q;
  assign busy = busy_q;
  // level length: each level lasts half cycles, which the caller keeps at two or more.
  always @(posedge clk_sys) begin
    if (go && !busy_q) begin
      busy_q <= 1'b1;
      left <= n_tog;
      cnt <= half;
    end else if (busy_q) begin
      if (cnt > 1) begin
        cnt <= cnt - 1;
      end else begin
        pin_q <= ~pin_q;
        cnt <= half;
        left <= left - 1;
        if (left == 1) begin
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the three-mode interval timer.
`timescale 1ns/100ps
`default_nettype none
module tb
  import tmt_pkg::*;
;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, irq, pin, go, busy;
  logic [7:0] half, n_tog;
  logic [31:0] exp_q[$];
  logic [15:0] v;
  int n_errors = 0;
  int check_count = 0;
  int h;
  logic [31:0] md [3] = '{32'h02, 32'h06, 32'h0A};

  tmt_interval_timer i_tmt_interval_timer (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .event_measure_input(pin), .irq(irq));
  tmt_pulse_src i_tmt_pulse_src (.clk_sys(clk_sys), .go(go), .half(half), .n_tog(n_tog),
    .pin(pin), .busy(busy));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The request is held until the edge at which ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask

  task automatic burst(input logic [7:0] hh, input logic [7:0] nt);
    half <= hh;
    n_tog <= nt;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy === 1'b1) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic see_irq(input logic exp);
    repeat (2) @(posedge clk_sys);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check("rdata", wb_dat_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, go} = 4'h0;
    wb_sel_i = 4'hF;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    half = 8'h04;
    n_tog = 8'h00;
    h = $urandom(32'h01ACD76F);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(TMT_ADR_MODE, 32'h20);
    rd(TMT_ADR_DATA, 32'h0);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0);
    v = 16'($urandom_range(40, 8));
    wr(TMT_ADR_MODE, 32'h00);
    wr(TMT_ADR_DATA, {16'h0, v});
    repeat (10) @(posedge clk_sys);
    rd(TMT_ADR_DATA, {16'h0, v});
    rd(TMT_ADR_MODE, 32'h00);
    wr(TMT_ADR_IRQ_MASK, 32'h1);
    wr(TMT_ADR_START, 32'h1);
    for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clk_sys);
    wr(TMT_ADR_START, 32'h0);
    rd(TMT_ADR_IRQ_STAT, 32'h1);
    rd(TMT_ADR_MODE, 32'h20);
    wr(TMT_ADR_IRQ_MASK, 32'h0);
    see_irq(1'b0);
    wr(TMT_ADR_IRQ_MASK, 32'h1);
    see_irq(1'b1);
    wr(TMT_ADR_IRQ_STAT, 32'h1);
    see_irq(1'b0);
    // Slow source: the first request lands within one source period of v+1 ticks.
    wr(TMT_ADR_MODE, 32'h40);
    wr(TMT_ADR_DATA, {16'h0, v});
    wr(TMT_ADR_START, 32'h1);
    wr(TMT_ADR_DATA, 32'h0123);
    h = 0;
    while (irq !== 1'b1 && h < 2000) begin
      @(posedge clk_sys);
      h++;
    end
    check("ticks", 32'((h + 1) >> TMT_PS_SHIFT[1]), {16'h0, v});
    rd(TMT_ADR_DATA, 32'h0123);
    for (int e = 0; e < 4; e++) begin
      wr(TMT_ADR_START, 32'h0);
      wr(TMT_ADR_MODE, 32'h01 | (e << 2));
      wr(TMT_ADR_DATA, 32'h20);
      wr(TMT_ADR_START, 32'h1);
      burst(8'h04, 8'h06);
      rd(TMT_ADR_DATA, 32'h20 - ((e == 2) ? 6 : (e == 3) ? 0 : 3));
    end
    wr(TMT_ADR_START, 32'h0);
    wr(TMT_ADR_MODE, 32'h03);
    wr(TMT_ADR_DATA, 32'h55);
    wr(TMT_ADR_START, 32'h1);
    burst(8'h04, 8'h02);
    rd(TMT_ADR_DATA, 32'h55);
    wr(TMT_ADR_START, 32'h0);
    wr(TMT_ADR_MODE, 32'h01);
    wr(TMT_ADR_DATA, 32'h2);
    wr(TMT_ADR_IRQ_STAT, 32'h1);
    wr(TMT_ADR_START, 32'h1);
    burst(8'h04, 8'h06);
    rd(TMT_ADR_DATA, 32'h2);
    rd(TMT_ADR_IRQ_STAT, 32'h1);
    h = 4 + $urandom_range(6);
    for (int m = 0; m < 3; m++) begin
      wr(TMT_ADR_START, 32'h0);
      wr(TMT_ADR_MODE, md[m]);
      wr(TMT_ADR_IRQ_STAT, 32'h1);
      wr(TMT_ADR_START, 32'h1);
      burst(8'(h), 8'h02);
      rd(TMT_ADR_IRQ_STAT, (m == 2) ? 32'h1 : 32'h0);
      burst(8'(h), 8'h06);
      rd(TMT_ADR_DATA, (m == 2) ? 32'(h - 1) : 32'(2 * h - 1));
      rd(TMT_ADR_IRQ_STAT, 32'h1);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
